// ==== hw/mrr_motion_regs.sv ====
// Motion accumulation, displacement hand-off, frame statistics and the
// main setup register of a laser motion sensor.
// Assumes a serial-port front end that turns each register access into
// a one-cycle read or write strobe with address, and an image pipeline
// that gives one strobe per frame with motion in 400 cpi base counts.
// A frame and a status read in one cycle both apply; a flush write
// drops the motion of a frame that lands in the same cycle.
//
// How it works
// - Status read snapshots X and Y displacement
// - Repeated status read replaces unread snapshot
// - Wide accumulators; overflow sets flag, path lost
// - Overflow clears after read, not full scale
// - Excess motion reads saturated; motion flag stays
// - Any flush write clears all stored motion
// - X register: 8-bit signed, resolution scaled
// - Y register: 8-bit signed, resolution scaled
// - Reading a displacement register clears it
// - Surface quality is features over four
// - Pixel total is upper byte of sum
// - Peak pixel six bits, top bits zero
// - Setup register read/write, resets to 0x49
// - Setup bit layout with fixed bits
// - Status bit 7 motion, bit 4 overflow
`timescale 1ns/1ns

module mrr_motion_regs (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Register access from the serial front end
    input  wire logic [6:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata_q,
    // Per-frame results from the image pipeline
    input  wire logic        frame_done,
    input  wire logic [7:0]  frame_dx,
    input  wire logic [7:0]  frame_dy,
    input  wire logic [9:0]  frame_features,
    input  wire logic [15:0] frame_pixel_sum,
    input  wire logic [5:0]  frame_peak,
    // Setup controls
    output logic             laser_gate_en,
    output logic             self_test_start_q,
    output logic             resolution_high_bit,
    output logic             resolution_low_bit
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]         setup_q;
    logic [7:0]         surface_quality_q;
    logic [7:0]         pixtot_q;
    logic [7:0]         peak_q;
    logic               accumulator_overflow_flag_q;
    logic               motion_pending_flag;
    logic signed [15:0] acc_q [2];
    logic signed [7:0]  disp_q [2];
    logic signed [7:0]  delta [2];
    logic [1:0]         ovf_evt;
    logic [1:0]         at_full;
    logic [1:0]         disp_rd;
    logic               status_rd;
    logic               flush_wr;
    logic               setup_wr;
    logic [2:0]         scale_f;
    logic [7:0]         status_val;
    logic [7:0]         setup_d;
    logic [7:0]         surface_quality_d;
    logic [7:0]         pixtot_d;
    logic [7:0]         rdata_d;
    logic               accumulator_overflow_flag_d;
    logic               ovf_set;
    logic               ovf_clear;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic signed [7:0] sat8(
        input logic signed [15:0] v
    );
        if (v > 16'(DISP_POS_FULL_W())) begin
            return mrr_pkg::DISP_POS_FULL;
        end else if (v < 16'(DISP_NEG_FULL_W())) begin
            return mrr_pkg::DISP_NEG_FULL;
        end
        return v[7:0];
    endfunction

    function automatic logic signed [7:0] DISP_POS_FULL_W();
        return mrr_pkg::DISP_POS_FULL;
    endfunction

    function automatic logic signed [7:0] DISP_NEG_FULL_W();
        return mrr_pkg::DISP_NEG_FULL;
    endfunction

    function automatic logic signed [11:0] scale(
        input logic signed [7:0] d,
        input logic [2:0]        f
    );
        logic signed [11:0] d12;
        d12 = 12'(d);
        return d12 * $signed({9'h000, f});
    endfunction

    // ****************************************
    // Access decode
    // ****************************************
    assign status_rd = reg_rd && (reg_addr == mrr_pkg::A_STATUS);
    assign disp_rd[0] = reg_rd && (reg_addr == mrr_pkg::A_XDISP);
    assign disp_rd[1] = reg_rd && (reg_addr == mrr_pkg::A_YDISP);
    assign flush_wr  = reg_wr && (reg_addr == mrr_pkg::A_FLUSH);
    assign setup_wr  = reg_wr && (reg_addr == mrr_pkg::A_SETUP);

    assign delta[0] = frame_dx;
    assign delta[1] = frame_dy;

    // Counts are reported at the selected resolution
    always_comb begin
        case ({setup_q[mrr_pkg::SU_RESH_BIT],
               setup_q[mrr_pkg::SU_RESL_BIT]})
            2'b00:   scale_f = mrr_pkg::SCALE_400;
            2'b01:   scale_f = mrr_pkg::SCALE_800;
            2'b10:   scale_f = mrr_pkg::SCALE_1600;
            default: scale_f = mrr_pkg::SCALE_2000;
        endcase
    end

    // ****************************************
    // Per-axis accumulator and snapshot
    // ****************************************
    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_axis
            logic signed [11:0] step;
            logic signed [7:0]  take;
            logic signed [17:0] sum;
            logic signed [15:0] acc_d;
            logic signed [7:0]  disp_d;

            always_comb begin
                step = frame_done ? scale(delta[a], scale_f) : 12'sh000;
                // Anything beyond one report stays behind as residue
                take = sat8(acc_q[a]);
                sum  = 18'(acc_q[a]) + 18'(step)
                     - (status_rd ? 18'(take) : 18'sh0_0000);
            end

            // Wider than a byte so fast motion survives slow polling
            assign ovf_evt[a] = (sum > 18'(mrr_pkg::ACC_MAX)) ||
                                (sum < 18'(mrr_pkg::ACC_MIN));
            assign at_full[a] = (acc_q[a] == mrr_pkg::ACC_MAX) ||
                                (acc_q[a] == mrr_pkg::ACC_MIN);

            // Clipping keeps the sign of a runaway axis; the path is lost
            always_comb begin
                if (sum > 18'(mrr_pkg::ACC_MAX)) begin
                    acc_d = mrr_pkg::ACC_MAX;
                end else if (sum < 18'(mrr_pkg::ACC_MIN)) begin
                    acc_d = mrr_pkg::ACC_MIN;
                end else begin
                    acc_d = sum[15:0];
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset || flush_wr) begin
                    acc_q[a] <= 16'sh0000;
                end else begin
                    acc_q[a] <= acc_d;
                end
            end

            // A fresh status read overwrites an unread snapshot
            always_comb begin
                disp_d = disp_q[a];
                if (status_rd) begin
                    disp_d = take;
                end else if (disp_rd[a]) begin
                    disp_d = mrr_pkg::DISP_RESET;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset || flush_wr) begin
                    disp_q[a] <= mrr_pkg::DISP_RESET;
                end else begin
                    disp_q[a] <= disp_d;
                end
            end
        end
    endgenerate

    // ****************************************
    // Motion and overflow flags
    // ****************************************
    // Motion stays pending while any residue remains
    assign motion_pending_flag = (acc_q[0] != 16'sh0000) ||
                                 (acc_q[1] != 16'sh0000);

    // Clear needs a displacement read and no axis pinned at a limit
    assign ovf_set   = |ovf_evt;
    assign ovf_clear = (|disp_rd) && !(|at_full);

    // New overflow wins over a clear in the same cycle
    always_comb begin
        accumulator_overflow_flag_d = accumulator_overflow_flag_q;
        if (ovf_set) begin
            accumulator_overflow_flag_d = 1'b1;
        end else if (ovf_clear) begin
            accumulator_overflow_flag_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || flush_wr) begin
            accumulator_overflow_flag_q <= 1'b0;
        end else begin
            accumulator_overflow_flag_q <= accumulator_overflow_flag_d;
        end
    end

    always_comb begin
        status_val = mrr_pkg::STAT_RESET;
        status_val[mrr_pkg::ST_MOTION_BIT] = motion_pending_flag;
        status_val[mrr_pkg::ST_OVF_BIT] =
            accumulator_overflow_flag_q;
        status_val[mrr_pkg::ST_RESH_BIT] = setup_q[mrr_pkg::SU_RESH_BIT];
        status_val[mrr_pkg::ST_RESL_BIT] = setup_q[mrr_pkg::SU_RESL_BIT];
    end

    // ****************************************
    // Frame statistics
    // ****************************************
    // Clamped so a wild pipeline value never breaks the printed range
    always_comb begin
        surface_quality_d = frame_features[9:2];
        if (surface_quality_d > mrr_pkg::SURFACE_QUALITY_MAX) begin
            surface_quality_d = mrr_pkg::SURFACE_QUALITY_MAX;
        end
    end

    always_comb begin
        pixtot_d = frame_pixel_sum[15:8];
        if (pixtot_d > mrr_pkg::PIXTOT_MAX) begin
            pixtot_d = mrr_pkg::PIXTOT_MAX;
        end
    end

    // Statistics follow the frame strobe and hold between frames
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            surface_quality_q <= 8'h00;
        end else if (frame_done) begin
            surface_quality_q <= surface_quality_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pixtot_q <= 8'h00;
        end else if (frame_done) begin
            pixtot_q <= pixtot_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            peak_q <= 8'h00;
        end else if (frame_done) begin
            peak_q <= {2'b00, frame_peak};
        end
    end

    // ****************************************
    // Setup register
    // ****************************************
    // Fixed bits are forced here so no write can ever change them
    always_comb begin
        setup_d = setup_q;
        if (setup_wr) begin
            setup_d = reg_wdata;
        end
        setup_d[mrr_pkg::SU_ZERO_BIT] = 1'b0;
        setup_d[mrr_pkg::SU_ONE_BIT]  = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            setup_q <= mrr_pkg::SETUP_RESET;
        end else begin
            setup_q <= setup_d;
        end
    end

    // Test launch is one pulse per write with the bit set
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            self_test_start_q <= 1'b0;
        end else begin
            self_test_start_q <= setup_wr &&
                                 reg_wdata[mrr_pkg::SU_TEST_BIT];
        end
    end

    assign laser_gate_en       = setup_q[mrr_pkg::SU_LASER_BIT];
    assign resolution_high_bit = setup_q[mrr_pkg::SU_RESH_BIT];
    assign resolution_low_bit  = setup_q[mrr_pkg::SU_RESL_BIT];

    // ****************************************
    // Read data
    // ****************************************
    // Unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            mrr_pkg::A_STATUS: rdata_d = status_val;
            mrr_pkg::A_XDISP:  rdata_d = disp_q[0];
            mrr_pkg::A_YDISP:  rdata_d = disp_q[1];
            mrr_pkg::A_SURFACE_QUALITY:  rdata_d = surface_quality_q;
            mrr_pkg::A_PIXTOT: rdata_d = pixtot_q;
            mrr_pkg::A_PEAK:   rdata_d = peak_q;
            mrr_pkg::A_SETUP:  rdata_d = setup_q;
            default:           rdata_d = 8'h00;
        endcase
    end

    // Read data holds until the next read so a slow host still sees it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

endmodule

// ==== hw/mrr_pkg.sv ====
// Constants for the motion report register block: register offsets,
// bit positions, reset values and full-scale limits.
// Assumes nothing of its surroundings; used by hw/mrr_motion_regs.sv.
package mrr_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam int unsigned ADDR_W = 7;
    localparam logic [6:0] A_STATUS = 7'h02;
    localparam logic [6:0] A_XDISP  = 7'h03;
    localparam logic [6:0] A_YDISP  = 7'h04;
    localparam logic [6:0] A_SURFACE_QUALITY  = 7'h05;
    localparam logic [6:0] A_PIXTOT = 7'h06;
    localparam logic [6:0] A_PEAK   = 7'h07;
    localparam logic [6:0] A_SETUP  = 7'h0a;
    localparam logic [6:0] A_FLUSH  = 7'h12;

    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int unsigned ST_MOTION_BIT = 7;
    localparam int unsigned ST_OVF_BIT    = 4;
    localparam int unsigned ST_RESH_BIT   = 2;
    localparam int unsigned ST_RESL_BIT   = 0;

    // ****************************************
    // Setup bit positions and reset value
    // ****************************************
    localparam int unsigned SU_ZERO_BIT  = 7;
    localparam int unsigned SU_LASER_BIT = 6;
    localparam int unsigned SU_TEST_BIT  = 5;
    localparam int unsigned SU_RESH_BIT  = 4;
    localparam int unsigned SU_ONE_BIT   = 3;
    localparam int unsigned SU_RESL_BIT  = 2;
    localparam logic [7:0] SETUP_RESET   = 8'h49;

    // ****************************************
    // Data reset values and limits
    // ****************************************
    localparam logic [7:0] DISP_RESET  = 8'h00;
    localparam logic [7:0] STAT_RESET  = 8'h00;
    localparam int unsigned ACC_W      = 16;
    localparam logic signed [15:0] ACC_MAX = 16'sh7fff;
    localparam logic signed [15:0] ACC_MIN = 16'sh8000;
    localparam logic signed [7:0] DISP_POS_FULL = 8'sh7f;
    localparam logic signed [7:0] DISP_NEG_FULL = 8'sh80;
    localparam logic [7:0] SURFACE_QUALITY_MAX   = 8'ha9;
    localparam logic [7:0] PIXTOT_MAX  = 8'hdd;

    // ****************************************
    // Count multipliers per resolution {high,low}
    // ****************************************
    localparam logic [2:0] SCALE_400  = 3'h1;
    localparam logic [2:0] SCALE_800  = 3'h2;
    localparam logic [2:0] SCALE_1600 = 3'h4;
    localparam logic [2:0] SCALE_2000 = 3'h5;

endpackage

// ==== test/mrr_host_model.sv ====
// Controller side of the register port: one read or write per call.
// Assumes every call starts just after a rising edge of ref_clk.
`timescale 1ns/1ns

module mrr_host_model (
    // Clock
    input  wire logic       ref_clk,
    // Register port
    output logic      [6:0] reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata_q
);
    // ****************************************
    // Register access
    // ****************************************
    initial begin
        reg_addr = 7'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released lines show the inverse, so a stale value never looks valid
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #2 reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge ref_clk);
        #2 d = reg_rdata_q;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #2 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // Idle edge, so the next call never redrives a line in this step
        @(posedge ref_clk);
        #2;
    endtask
endmodule

// ==== test/mrr_motion_regs_properties.sv ====
// Port checks for the motion report register block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns

module mrr_motion_regs_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    // Setup outputs
    input wire logic       laser_gate_en,
    input wire logic       self_test_start_q,
    input wire logic       resolution_high_bit,
    input wire logic       resolution_low_bit
);
    // ****************************************
    // Properties
    // ****************************************
    logic       wr_su;
    logic [7:0] su;
    assign wr_su = reg_wr && reg_addr == mrr_pkg::A_SETUP;
    assign su = {1'b0, laser_gate_en, 1'b0, resolution_high_bit, 1'b0,
                 resolution_low_bit, 2'b00};

    function automatic logic rd_is(logic [6:0] a);
        return reg_rd && reg_addr == a;
    endfunction

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_setup; wr_su |=> su == ($past(reg_wdata) & 8'h54); endproperty
    a_setup: assert property (p_setup) else $error("setup outputs");
    property p_test; wr_su && reg_wdata[5] |=> self_test_start_q; endproperty
    a_test: assert property (p_test) else $error("no self test pulse");
    property p_test_off; !(wr_su && reg_wdata[5]) |=> !self_test_start_q;
    endproperty
    a_test_off: assert property (p_test_off) else $error("stray pulse");
    property p_setup_rd;
        rd_is(mrr_pkg::A_SETUP) |=> (reg_rdata_q & 8'hdc) == (su | 8'h08);
    endproperty
    a_setup_rd: assert property (p_setup_rd) else $error("setup read");
    property p_peak; rd_is(mrr_pkg::A_PEAK) |=> reg_rdata_q[7:6] == 2'b00;
    endproperty
    a_peak: assert property (p_peak) else $error("peak top bits set");
    property p_surface_quality;
        rd_is(mrr_pkg::A_SURFACE_QUALITY) |=> reg_rdata_q <= mrr_pkg::SURFACE_QUALITY_MAX;
    endproperty
    a_surface_quality: assert property (p_surface_quality) else $error("quality too big");
    property p_pixtot;
        rd_is(mrr_pkg::A_PIXTOT) |=> reg_rdata_q <= mrr_pkg::PIXTOT_MAX;
    endproperty
    a_pixtot: assert property (p_pixtot) else $error("total too big");
    property p_status; rd_is(mrr_pkg::A_STATUS) |=>
        (reg_rdata_q & 8'h6f) == ((su >> 2) & 8'h05); endproperty
    a_status: assert property (p_status) else $error("status bits");
    property p_xclear; rd_is(mrr_pkg::A_XDISP) ##1 !reg_rd ##1
        rd_is(mrr_pkg::A_XDISP) |=> reg_rdata_q == 8'h00; endproperty
    a_xclear: assert property (p_xclear) else $error("x not cleared");
endmodule

bind mrr_motion_regs mrr_motion_regs_chk chk_u (.ref_clk, .reset,
    .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q, .laser_gate_en,
    .self_test_start_q, .resolution_high_bit, .resolution_low_bit);

// ==== test/tb_motion_report_registers.sv ====
// Bench for the motion report register block: model, stimulus, verdict.
// Assumes mrr_host_model on the register port and the bound checker.
`timescale 1ns/1ns

module tb_motion_report_registers;
    // ****************************************
    // Model, stimulus and checks
    // ****************************************
    logic        ref_clk, reset, frame_done, reg_rd, reg_wr;
    logic        laser_gate_en, self_test_start_q;
    logic        resolution_high_bit, resolution_low_bit;
    logic [6:0]  reg_addr;
    logic [7:0]  frame_dx, frame_dy, reg_wdata, reg_rdata_q, got, setup, e;
    logic [9:0]  frame_features;
    logic [15:0] frame_pixel_sum;
    logic [5:0]  frame_peak;
    logic        test_seen;
    logic [31:0] seed;
    int          ax, ay, sx, sy, ovf, sq, pt, pk, failures, compares;

    mrr_motion_regs dut_u (.ref_clk, .reset, .reg_addr, .reg_rd, .reg_wr,
        .reg_wdata, .reg_rdata_q, .frame_done, .frame_dx, .frame_dy,
        .frame_features, .frame_pixel_sum, .frame_peak, .laser_gate_en,
        .self_test_start_q, .resolution_high_bit, .resolution_low_bit);
    mrr_host_model host_u (.ref_clk, .reg_addr, .reg_rd, .reg_wr,
        .reg_wdata, .reg_rdata_q);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // The test pulse is gone by the time a write task returns
    always @(posedge ref_clk) test_seen <= self_test_start_q;

    function void xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction
    function int sat(int v, int lo, int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    // Accumulators clip at full scale, so overflow loses the path
    function int acc(int a, int d);
        int v;
        v = a + d * ({setup[4], setup[2]} == 2'b11 ?
                     5 : 1 << {setup[4], setup[2]});
        if (v > 32767 || v < -32768) ovf = 1;
        return sat(v, -32768, 32767);
    endfunction

    task chk(logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task frame(int dx, int dy);
        xs();
        frame_dx = dx[7:0];
        frame_dy = dy[7:0];
        {frame_pixel_sum, frame_peak, frame_features} = seed;
        frame_done = 1'b1;
        @(posedge ref_clk);
        #2 frame_done = 1'b0;
        // Idle edge keeps back-to-back frames from redriving the strobe
        @(posedge ref_clk);
        #2;
        ax = acc(ax, dx);
        ay = acc(ay, dy);
        sq = sat(frame_features / 4, 0, 169);
        pt = sat(frame_pixel_sum / 256, 0, 221);
        pk = frame_peak;
    endtask
    task rs();
        e = {ax != 0 || ay != 0, 2'b00, ovf[0], 1'b0, setup[4], 1'b0,
             setup[2]};
        host_u.rd(mrr_pkg::A_STATUS, got);
        chk(got, e);
        sx = sat(ax, -128, 127);
        sy = sat(ay, -128, 127);
        ax -= sx;
        ay -= sy;
    endtask
    task rdisp(logic [6:0] a, inout int s);
        host_u.rd(a, got);
        chk(got, s[7:0]);
        s = 0;
        if (!(ax inside {32767, -32768} || ay inside {32767, -32768})) ovf = 0;
    endtask
    task report();
        rs();
        rdisp(mrr_pkg::A_XDISP, sx);
        rdisp(mrr_pkg::A_YDISP, sy);
    endtask
    task rstats();
        host_u.rd(mrr_pkg::A_SURFACE_QUALITY, got);
        chk(got, sq[7:0]);
        host_u.rd(mrr_pkg::A_PIXTOT, got);
        chk(got, pt[7:0]);
        host_u.rd(mrr_pkg::A_PEAK, got);
        chk(got, pk[7:0]);
    endtask
    task wsetup(logic [7:0] v);
        host_u.wr(mrr_pkg::A_SETUP, v);
        setup = {1'b0, v[6:4], 1'b1, v[2:0]};
        e = {4'h0, laser_gate_en, test_seen, resolution_high_bit,
             resolution_low_bit};
        chk(e, {4'h0, v[6], v[5], v[4], v[2]});
        host_u.rd(mrr_pkg::A_SETUP, got);
        chk(got, setup);
    endtask
    task print_verdict();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        frame_done = 1'b0;
        {frame_dx, frame_dy, frame_features, frame_pixel_sum} = '0;
        frame_peak = 6'h00;
        seed = 32'h0000_8835;
        setup = 8'h49;
        {ax, ay, sx, sy, ovf, sq, pt, pk, failures, compares} = '0;
        repeat (20) @(posedge ref_clk);
        #2 reset = 1'b0;
        host_u.rd(mrr_pkg::A_SETUP, got);
        chk(got, 8'h49);
        rstats();
        report();
        for (int i = 0; i < 4; i++) begin
            xs();
            wsetup({seed[7:5], i[1], seed[3], i[0], seed[1:0]});
            xs();
            frame($signed(seed[7:0]), $signed(seed[15:8]));
            rstats();
            repeat (6) report();
        end
        frame(5, -5);
        rs();
        frame(7, 7);
        rs();
        rdisp(mrr_pkg::A_XDISP, sx);
        rdisp(mrr_pkg::A_XDISP, sx);
        rdisp(mrr_pkg::A_YDISP, sy);
        wsetup(8'h34);
        repeat (60) frame(127, -128);
        repeat (2) report();
        host_u.wr(mrr_pkg::A_FLUSH, 8'h5a);
        {ax, ay, sx, sy, ovf} = '0;
        report();
        print_verdict();
    end
endmodule
